// ### common/lpgd_map.svh
// Register offsets, field positions, reset values and timing figures.
`ifndef LPGD_MAP_SVH
`define LPGD_MAP_SVH
`define LPGD_MODE_OFS 8'h00
`define LPGD_GRP_OFS 8'h04
`define LPGD_LEDOUT_OFS 8'h08
`define LPGD_ERR_OPEN_OFS 8'h0C
`define LPGD_ERR_SHORT_OFS 8'h10
`define LPGD_STATUS_OFS 8'h14
`define LPGD_CALL_OFS 8'h18
`define LPGD_OWN_OFS 8'h1C
`define LPGD_GRADEN_OFS 8'h20
`define LPGD_GRADSEL_OFS 8'h24
`define LPGD_GRADRUN_OFS 8'h28
`define LPGD_COMMIT_OFS 8'h2C
`define LPGD_BUS_SOFT_RESET_CALL_OFS 8'h30
`define LPGD_GCFG_BASE 2'h1
`define LPGD_CHAN_BASE 2'h2
`define LPGD_MODE_BLINK 0
`define LPGD_MODE_UPD_ACK 1
`define LPGD_MODE_EXP 2
`define LPGD_MODE_EN_GRP 4
`define LPGD_MODE_EN_SUB1 5
`define LPGD_MODE_EN_SUB2 6
`define LPGD_MODE_EN_SUB3 7
`define LPGD_MODE_RST 8'h20
`define LPGD_GRP_DUTY_RST 8'hFF
`define LPGD_GRP_CALL_RST 7'h70
`define LPGD_BUS_SOFT_RESET_CALL_KEY 8'hA5
`define LPGD_CLK_MHZ 8'd100
`define LPGD_OSC_MHZ 8'd8
`define LPGD_STEP_MIN_US 500
`define LPGD_CLK_NS 10
`define LPGD_BLINK_DIV 8
`define LPGD_STEP_COARSE 14'd32
`define LPGD_CAPTURE_WAIT 3'd5
`endif

// ### common/lpgd_pkg.sv
// Types shared by the LED PWM gradation driver.
package lpgd_pkg;
   typedef enum logic [1:0] {LPGD_OFF, LPGD_ON, LPGD_IND, LPGD_IND_GRP}
      lpgd_ledmode_t;
   typedef enum logic [2:0] {LPGD_IDLE, LPGD_UP, LPGD_HOLD_ON, LPGD_DOWN,
      LPGD_HOLD_OFF, LPGD_DONE} lpgd_grad_t;
endpackage : lpgd_pkg

// ### hdl/lpgd_top.sv
// Sixteen channel LED PWM gradation driver core with an AHB-Lite slave.
//
// Contract
// - Sixteen 8-bit channel PWMs at 31.25 kHz.
// - Shared group PWM, 122 Hz dim or blink.
// - Per output off, on, PWM, PWM with group.
// - Per channel 8-bit peak current value.
// - Four gradation groups with own settings.
// - Gradation single shot or continuous repeat.
// - Channel normal or gradation, selects group.
// - Open, short, overtemperature reported in status.
// - Overtemperature shuts outputs down autonomously.
// - Output enable low allows outputs, high blanks.
// - Group call and three sub calls, enableable.
// - Default sub call identifies sixteen channel part.
// - Soft reset call restores all defaults.
// - Programmable per output turn-on delay.
// - Ramp up and down enables, rate.
// - 6-bit step time, 0.5 to 512 ms.
// - 3-bit hold on and off, 0 to 6 s.
// - Gradation curve linear or exponential.
// - Reset: channel duty off, group duty full.
// - Update per write or on commit, commit default.
// - PWM timing from an 8 MHz internal tick; gradation steps from HALF_MS_CYC hclk cycles.
// - Own address from three five-state pins.
// - Address pins sampled only after reset.
// - Active low hardware reset input.
`timescale 1ns/1ns
`include "lpgd_map.svh"
module lpgd_top
   import lpgd_pkg::*;
#(
   parameter int HALF_MS_CYC = `LPGD_STEP_MIN_US * 1000 / `LPGD_CLK_NS,
   parameter logic [6:0] SUB16_ADDR = 7'h3A
)
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device pins and sensors.
   input wire logic oe_n,
   input wire logic [2:0] addr_select_pin_0,
   input wire logic [2:0] addr_select_pin_1,
   input wire logic [2:0] addr_select_pin_2,
   input wire logic [15:0] open_det,
   input wire logic [15:0] short_det,
   input wire logic overtemp,
   // Outputs to the current sinks.
   output logic [15:0] current_sink_outputs,
   output logic [15:0][7:0] sink_current,
   // Call address match.
   input wire logic [6:0] probe_addr,
   output logic addr_hit
);
   localparam int SW = 43;
   localparam logic [16:0] HMS_LAST = 17'(HALF_MS_CYC - 1);

   function automatic logic [6:0] quin_addr(input logic [8:0] ad);
      logic [6:0] a0, a1, a2;
      a0 = (ad[2:0] > 3'd4) ? 7'd4 : {4'd0, ad[2:0]};
      a1 = (ad[5:3] > 3'd4) ? 7'd4 : {4'd0, ad[5:3]};
      a2 = (ad[8:6] > 3'd4) ? 7'd4 : {4'd0, ad[8:6]};
      return 7'(7'd1 + a0 + 7'd5 * a1 + 7'd25 * a2);
   endfunction : quin_addr

   function automatic logic [13:0] step_hms(input logic [5:0] c);
      logic [13:0] n;
      n = {9'd0, c[4:0]} + 14'd1;
      return c[5] ? 14'(n * `LPGD_STEP_COARSE) : n;
   endfunction : step_hms

   function automatic logic [13:0] hold_hms(input logic [2:0] c);
      logic [13:0] v;
      v = 14'd0;
      unique case (c)
         3'd0: v = 14'd0;
         3'd1: v = 14'd500;
         3'd2: v = 14'd1000;
         3'd3: v = 14'd1500;
         3'd4: v = 14'd2000;
         3'd5: v = 14'd4000;
         3'd6: v = 14'd8000;
         3'd7: v = 14'd12000;
      endcase
      return v;
   endfunction : hold_hms

   function automatic logic [7:0] curve(input logic [7:0] l, input logic e);
      logic [17:0] p;
      p = ({10'd0, l} + 18'd1) * ({10'd0, l} + 18'd1) - 18'd1;
      return e ? p[15:8] : l;
   endfunction : curve

   // Bus slave state and registers.
   logic wr_q, srst_q, ap, we;
   logic [7:0] wa_q;
   logic [31:0] rd_d, rd_q;
   logic [7:0] mode_q, grp_duty_q, grp_freq_q;
   logic [31:0] ledout_q, ledout_act_q, call_q, gradsel_q;
   logic [15:0][7:0] duty_q, duty_act_q, iref_q, dly_q;
   logic [15:0] graden_q, err_open_q, err_short_q;
   logic [3:0] gradrun_q, gradcont_q;
   logic [3:0][31:0] gcfg_q;
   logic ot_seen_q;
   logic [6:0] own_q;
   logic [2:0] cap_q;
   // Timing and pin synchronisers.
   logic [7:0] acc_q, pwm_cnt_q, gcnt_q;
   logic tick_q, hms_tick;
   logic [10:0] gdiv_q;
   logic [16:0] hms_q;
   logic [SW-1:0] s1_q, s2_q, s3_q, st_q;
   logic oe_off, ot_on, grp_on;
   // Gradation engines.
   lpgd_grad_t [3:0] gst_q;
   logic [3:0][7:0] glvl_q;
   logic [3:0][13:0] gtmr_q;

   assign ap = hsel & hready & htrans[1];
   assign we = wr_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   assign oe_off = st_q[0];
   assign ot_on = st_q[1];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         rd_q <= 32'h0000_0000;
      end
      else
      begin
         wr_q <= ap & hwrite;
         wa_q <= haddr[7:0];
         if (ap && !hwrite)
            rd_q <= rd_d;
      end
   end

   // Soft reset lasts one cycle and then restores the configuration, shadow, error, capture and gradation registers below.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         srst_q <= 1'b0;
      else
         srst_q <= we && wa_q == `LPGD_BUS_SOFT_RESET_CALL_OFS
            && hwdata[7:0] == `LPGD_BUS_SOFT_RESET_CALL_KEY;
   end

   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (haddr[7:6] == `LPGD_CHAN_BASE)
         rd_d = {8'h00, dly_q[haddr[5:2]], iref_q[haddr[5:2]],
            duty_q[haddr[5:2]]};
      else if (haddr[7:6] == `LPGD_GCFG_BASE && haddr[5:4] == 2'd0)
         rd_d = gcfg_q[haddr[3:2]];
      else
         unique case (haddr[7:0])
            `LPGD_MODE_OFS: rd_d = {24'h0, mode_q};
            `LPGD_GRP_OFS: rd_d = {16'h0, grp_freq_q, grp_duty_q};
            `LPGD_LEDOUT_OFS: rd_d = ledout_q;
            `LPGD_ERR_OPEN_OFS: rd_d = {16'h0, err_open_q};
            `LPGD_ERR_SHORT_OFS: rd_d = {16'h0, err_short_q};
            `LPGD_STATUS_OFS: rd_d = {30'h0, ot_seen_q, ot_on};
            `LPGD_CALL_OFS: rd_d = call_q;
            `LPGD_OWN_OFS: rd_d = {25'h0, own_q};
            `LPGD_GRADEN_OFS: rd_d = {16'h0, graden_q};
            `LPGD_GRADSEL_OFS: rd_d = gradsel_q;
            `LPGD_GRADRUN_OFS: rd_d = {24'h0, gradcont_q, gradrun_q};
            default: rd_d = 32'h0000_0000;
         endcase
   end

   // Writable configuration; both resets give the same defaults.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= `LPGD_MODE_RST;
         grp_duty_q <= `LPGD_GRP_DUTY_RST;
         grp_freq_q <= 8'h00;
         ledout_q <= 32'h0000_0000;
         duty_q <= '0;
         iref_q <= '0;
         dly_q <= '0;
         call_q <= {1'b0, 7'h00, 1'b0, 7'h00, 1'b0, SUB16_ADDR, 1'b0,
            `LPGD_GRP_CALL_RST};
         graden_q <= 16'h0000;
         gradsel_q <= 32'h0000_0000;
         gradrun_q <= 4'h0;
         gradcont_q <= 4'h0;
         gcfg_q <= '0;
      end
      else if (srst_q)
      begin
         mode_q <= `LPGD_MODE_RST;
         grp_duty_q <= `LPGD_GRP_DUTY_RST;
         grp_freq_q <= 8'h00;
         ledout_q <= 32'h0000_0000;
         duty_q <= '0;
         iref_q <= '0;
         dly_q <= '0;
         call_q <= {1'b0, 7'h00, 1'b0, 7'h00, 1'b0, SUB16_ADDR, 1'b0,
            `LPGD_GRP_CALL_RST};
         graden_q <= 16'h0000;
         gradsel_q <= 32'h0000_0000;
         gradrun_q <= 4'h0;
         gradcont_q <= 4'h0;
         gcfg_q <= '0;
      end
      else if (we)
      begin
         if (wa_q[7:6] == `LPGD_CHAN_BASE)
         begin
            duty_q[wa_q[5:2]] <= hwdata[7:0];
            iref_q[wa_q[5:2]] <= hwdata[15:8];
            dly_q[wa_q[5:2]] <= hwdata[23:16];
         end
         else if (wa_q[7:6] == `LPGD_GCFG_BASE && wa_q[5:4] == 2'd0)
            gcfg_q[wa_q[3:2]] <= hwdata;
         else
            unique case (wa_q)
               `LPGD_MODE_OFS: mode_q <= hwdata[7:0];
               `LPGD_GRP_OFS:
               begin
                  grp_duty_q <= hwdata[7:0];
                  grp_freq_q <= hwdata[15:8];
               end
               `LPGD_LEDOUT_OFS: ledout_q <= hwdata;
               `LPGD_CALL_OFS: call_q <= hwdata;
               `LPGD_GRADEN_OFS: graden_q <= hwdata[15:0];
               `LPGD_GRADSEL_OFS: gradsel_q <= hwdata;
               `LPGD_GRADRUN_OFS:
               begin
                  gradrun_q <= hwdata[3:0];
                  gradcont_q <= hwdata[7:4];
               end
               default: ;
            endcase
      end
   end

   // Shadowed settings reach the outputs per write or on commit.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ledout_act_q <= 32'h0000_0000;
         duty_act_q <= '0;
      end
      else if (srst_q)
      begin
         ledout_act_q <= 32'h0000_0000;
         duty_act_q <= '0;
      end
      else if (mode_q[`LPGD_MODE_UPD_ACK]
         || (we && wa_q == `LPGD_COMMIT_OFS))
      begin
         ledout_act_q <= ledout_q;
         duty_act_q <= duty_q;
      end
   end

   // Error flags are sticky; a new detection beats a write-one clear.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         err_open_q <= 16'h0000;
         err_short_q <= 16'h0000;
         ot_seen_q <= 1'b0;
      end
      else if (srst_q)
      begin
         err_open_q <= 16'h0000;
         err_short_q <= 16'h0000;
         ot_seen_q <= 1'b0;
      end
      else
      begin
         err_open_q <= (err_open_q & ~((we && wa_q == `LPGD_ERR_OPEN_OFS)
            ? hwdata[15:0] : 16'h0000)) | st_q[17:2];
         err_short_q <= (err_short_q & ~((we && wa_q == `LPGD_ERR_SHORT_OFS)
            ? hwdata[15:0] : 16'h0000)) | st_q[33:18];
         ot_seen_q <= (ot_seen_q & ~(we && wa_q == `LPGD_STATUS_OFS
            && hwdata[1])) | ot_on;
      end
   end

   // Pins settle through three stages; a bit moves once stages agree.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= SW'(1);
      end
      else
      begin
         s1_q <= {addr_select_pin_2, addr_select_pin_1, addr_select_pin_0,
            short_det, open_det, overtemp, oe_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
      end
   end

   // Address pins are caught once per reset or soft reset, after the synchronisers settle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cap_q <= 3'd0;
         own_q <= 7'h00;
      end
      else if (srst_q)
         cap_q <= 3'd0;
      else if (cap_q != `LPGD_CAPTURE_WAIT)
      begin
         cap_q <= cap_q + 3'd1;
         if (cap_q == `LPGD_CAPTURE_WAIT - 3'd1)
            own_q <= quin_addr(st_q[42:34]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         addr_hit_q_blk: addr_hit <= 1'b0;
      else
         addr_hit <= probe_addr == own_q
            || (mode_q[`LPGD_MODE_EN_GRP] && probe_addr == call_q[6:0])
            || (mode_q[`LPGD_MODE_EN_SUB1] && probe_addr == call_q[14:8])
            || (mode_q[`LPGD_MODE_EN_SUB2] && probe_addr == call_q[22:16])
            || (mode_q[`LPGD_MODE_EN_SUB3]
            && probe_addr == call_q[30:24]);
   end

   // An 8 MHz tick from a fractional accumulator, on average exact.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_q <= 8'd0;
         tick_q <= 1'b0;
      end
      else if (acc_q + `LPGD_OSC_MHZ >= `LPGD_CLK_MHZ)
      begin
         acc_q <= acc_q + `LPGD_OSC_MHZ - `LPGD_CLK_MHZ;
         tick_q <= 1'b1;
      end
      else
      begin
         acc_q <= acc_q + `LPGD_OSC_MHZ;
         tick_q <= 1'b0;
      end
   end

   // 256 ticks make one channel period; periods clock the group PWM.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pwm_cnt_q <= 8'd0;
         gdiv_q <= 11'd0;
         gcnt_q <= 8'd0;
      end
      else if (tick_q)
      begin
         pwm_cnt_q <= pwm_cnt_q + 8'd1;
         if (pwm_cnt_q == 8'hFF)
         begin
            if (!mode_q[`LPGD_MODE_BLINK]
               || gdiv_q == {grp_freq_q, 3'b111})
            begin
               gdiv_q <= 11'd0;
               gcnt_q <= gcnt_q + 8'd1;
            end
            else
               gdiv_q <= gdiv_q + 11'd1;
         end
      end
   end

   assign grp_on = gcnt_q < grp_duty_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hms_q <= 17'd0;
      else
         hms_q <= (hms_q == HMS_LAST) ? 17'd0 : hms_q + 17'd1;
   end

   assign hms_tick = hms_q == HMS_LAST;

   // Each group walks up, holds, walks down and holds off.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gst_q <= {4{LPGD_IDLE}};
         glvl_q <= '0;
         gtmr_q <= '0;
      end
      else
         for (int g = 0; g < 4; g++)
         begin
            if (srst_q || !gradrun_q[g])
            begin
               gst_q[g] <= LPGD_IDLE;
               glvl_q[g] <= 8'd0;
               gtmr_q[g] <= 14'd0;
            end
            else if (hms_tick && gtmr_q[g] != 14'd0)
               gtmr_q[g] <= gtmr_q[g] - 14'd1;
            else if (hms_tick)
               unique case (gst_q[g])
                  LPGD_IDLE, LPGD_HOLD_OFF:
                  begin
                     if (gst_q[g] == LPGD_HOLD_OFF && !gradcont_q[g])
                        gst_q[g] <= LPGD_DONE;
                     else if (gcfg_q[g][7])
                     begin
                        gst_q[g] <= LPGD_UP;
                        glvl_q[g] <= 8'd0;
                        gtmr_q[g] <= step_hms(gcfg_q[g][13:8]);
                     end
                     else
                     begin
                        gst_q[g] <= LPGD_HOLD_ON;
                        glvl_q[g] <= gcfg_q[g][31:24];
                        gtmr_q[g] <= hold_hms(gcfg_q[g][18:16]);
                     end
                  end
                  LPGD_UP:
                     if ({1'b0, glvl_q[g]} + {3'd0, gcfg_q[g][5:0]}
                        >= {1'b0, gcfg_q[g][31:24]}
                        || gcfg_q[g][5:0] == 6'd0)
                     begin
                        gst_q[g] <= LPGD_HOLD_ON;
                        glvl_q[g] <= gcfg_q[g][31:24];
                        gtmr_q[g] <= hold_hms(gcfg_q[g][18:16]);
                     end
                     else
                     begin
                        glvl_q[g] <= glvl_q[g] + {2'd0, gcfg_q[g][5:0]};
                        gtmr_q[g] <= step_hms(gcfg_q[g][13:8]);
                     end
                  LPGD_HOLD_ON:
                     if (gcfg_q[g][6])
                     begin
                        gst_q[g] <= LPGD_DOWN;
                        gtmr_q[g] <= step_hms(gcfg_q[g][13:8]);
                     end
                     else
                     begin
                        gst_q[g] <= LPGD_HOLD_OFF;
                        glvl_q[g] <= 8'd0;
                        gtmr_q[g] <= hold_hms(gcfg_q[g][21:19]);
                     end
                  LPGD_DOWN:
                     if (glvl_q[g] <= {2'd0, gcfg_q[g][5:0]})
                     begin
                        gst_q[g] <= LPGD_HOLD_OFF;
                        glvl_q[g] <= 8'd0;
                        gtmr_q[g] <= hold_hms(gcfg_q[g][21:19]);
                     end
                     else
                     begin
                        glvl_q[g] <= glvl_q[g] - {2'd0, gcfg_q[g][5:0]};
                        gtmr_q[g] <= step_hms(gcfg_q[g][13:8]);
                     end
                  LPGD_DONE: ;
               endcase
         end
   end

   // Delay shifts each channel's phase so edges do not coincide.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         current_sink_outputs <= 16'h0000;
         sink_current <= '0;
      end
      else
         for (int i = 0; i < 16; i++)
         begin
            logic ind_on, on;
            logic [7:0] ph;
            logic [1:0] grp;
            ph = pwm_cnt_q - dly_q[i];
            ind_on = duty_act_q[i] == 8'hFF || ph < duty_act_q[i];
            grp = gradsel_q[2*i +: 2];
            unique case (lpgd_ledmode_t'(ledout_act_q[2*i +: 2]))
               LPGD_OFF: on = 1'b0;
               LPGD_ON: on = 1'b1;
               LPGD_IND: on = ind_on;
               LPGD_IND_GRP: on = ind_on & grp_on;
            endcase
            // Both gates act after the channel logic so nothing bypasses them.
            current_sink_outputs[i] <= on & ~oe_off
               & ~ot_on;
            sink_current[i] <= graden_q[i]
               ? curve(glvl_q[grp], mode_q[`LPGD_MODE_EXP])
               : iref_q[i];
         end
   end

   ot_shut_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ot_on |=> current_sink_outputs == 16'h0000)
      else $error("outputs on during overtemperature");
   oe_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      oe_off |=> current_sink_outputs == 16'h0000)
      else $error("outputs on while enable is high");
   full_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ledout_act_q[1:0] == 2'd1 && !oe_off && !ot_on
      |=> current_sink_outputs[0])
      else $error("full-on channel not driven");
   soft_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
      srst_q |=> grp_duty_q == 8'hFF && duty_q == '0 && ledout_q == '0
      ##1 current_sink_outputs == 16'h0000)
      else $error("soft reset left state behind");
   pwm_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tick_q |=> !tick_q [*8])
      else $error("pwm tick faster than 8 MHz");
   commit_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !mode_q[1] && !(we && wa_q == 8'h2C) && !srst_q
      |=> $stable(duty_act_q) && $stable(ledout_act_q))
      else $error("active settings moved without commit");
   grad_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gst_q[0] == LPGD_HOLD_ON |-> glvl_q[0] == gcfg_q[0][31:24])
      else $error("hold-on level not final");
   err_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q[2] && !srst_q |=> err_open_q[0])
      else $error("open error not recorded");
   addr_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_q == 3'd5 && !srst_q |=> $stable(own_q))
      else $error("own address changed after capture");
   single_shot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gst_q[0] == LPGD_DONE && gradrun_q[0] && !srst_q
      |=> gst_q[0] == LPGD_DONE)
      else $error("single shot restarted");
endmodule : lpgd_top

// ### verification/lpgd_host_model.sv
// AHB-Lite master standing in for the host that programs the driver.
`timescale 1ns/1ns
module lpgd_host_model
(
   // Bus clock and answer.
   input wire logic hclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // Request.
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // One single word transfer; the data phase is held until hready.
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : lpgd_host_model

// ### verification/tb.sv
// Self-checking bench for the LED PWM gradation driver core.
`timescale 1ns/1ns
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, addr_hit;
   logic oe_n = 1'b0;
   logic overtemp = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] open_det = 16'h0;
   logic [15:0] short_det = 16'h0;
   logic [15:0] current_sink_outputs;
   logic [15:0][7:0] sink_current;
   logic [6:0] probe_addr = 7'h00;
   int err_count = 0;
   int cmp_count = 0;
   always #5 hclk = ~hclk;
   lpgd_host_model lpgd_host_model_i (.hclk(hclk), .hreadyout(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   lpgd_top #(.HALF_MS_CYC(20)) lpgd_top_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .oe_n(oe_n),
      .addr_select_pin_0(3'h1), .addr_select_pin_1(3'h2),
      .addr_select_pin_2(3'h0), .open_det(open_det), .short_det(short_det),
      .overtemp(overtemp), .current_sink_outputs(current_sink_outputs),
      .sink_current(sink_current), .probe_addr(probe_addr),
      .addr_hit(addr_hit));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      lpgd_host_model_i.xfer(1'b1, a, d, rd);
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      lpgd_host_model_i.xfer(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask : rdc
   // Pins pass a synchroniser, so outputs are judged after settling.
   task automatic settle();
      repeat (8) @(posedge hclk);
   endtask : settle
   task automatic t_defaults();
      rdc(32'h00, 32'h20);
      rdc(32'h04, 32'hFF);
      rdc(32'h1C, 32'h0C);
      rdc(32'hFC, 32'h0);
      chk(current_sink_outputs, 16'h0);
      chk(hresp, 1'b0);
      $display("test defaults done");
   endtask : t_defaults
   task automatic t_outputs();
      wr(32'h84, 32'h5A00);
      wr(32'h08, 32'h1);
      settle();
      chk(current_sink_outputs, 16'h0);
      wr(32'h2C, 32'h1);
      settle();
      chk(current_sink_outputs, 16'h1);
      chk(sink_current[1], 8'h5A);
      oe_n <= 1'b1;
      settle();
      chk(current_sink_outputs, 16'h0);
      oe_n <= 1'b0;
      settle();
      chk(current_sink_outputs, 16'h1);
      $display("test outputs done");
   endtask : t_outputs
   task automatic t_errors();
      open_det <= 16'h0009;
      short_det <= 16'h8000;
      overtemp <= 1'b1;
      settle();
      chk(current_sink_outputs, 16'h0);
      open_det <= 16'h0;
      short_det <= 16'h0;
      overtemp <= 1'b0;
      rdc(32'h0C, 32'h0009);
      rdc(32'h10, 32'h8000);
      rdc(32'h14, 32'h2);
      wr(32'h0C, 32'h0009);
      rdc(32'h0C, 32'h0);
      $display("test errors done");
   endtask : t_errors
   task automatic probe(input logic [6:0] a, input logic exp);
      @(posedge hclk);
      probe_addr <= a;
      repeat (3) @(posedge hclk);
      chk(addr_hit, exp);
   endtask : probe
   task automatic t_calls();
      probe(7'h0C, 1'b1);
      probe(7'h3A, 1'b1);
      probe(7'h70, 1'b0);
      wr(32'h00, 32'h30);
      probe(7'h70, 1'b1);
      $display("test calls done");
   endtask : t_calls
   // Group 0 ramps in two steps of 32 to 0x40, then ends single shot.
   task automatic t_grad();
      logic seen;
      seen = 1'b0;
      wr(32'h40, 32'h400000A0);
      wr(32'h20, 32'h4);
      wr(32'h28, 32'h1);
      repeat (400)
      begin
         @(posedge hclk);
         if (sink_current[2] == 8'h40)
            seen = 1'b1;
      end
      chk(seen, 1'b1);
      chk(sink_current[2], 8'h00);
      $display("test gradation done");
   endtask : t_grad
   task automatic t_bus_soft_reset_call();
      wr(32'h30, 32'hA5);
      settle();
      chk(current_sink_outputs, 16'h0);
      rdc(32'h00, 32'h20);
      rdc(32'h1C, 32'h0C);
      $display("test soft reset done");
   endtask : t_bus_soft_reset_call
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      t_defaults();
      t_outputs();
      t_errors();
      t_calls();
      t_grad();
      t_bus_soft_reset_call();
      close_out();
   end
   // The tests need well under 2000 cycles.
   initial
   begin
      #100000;
      err_count++;
      close_out();
   end
endmodule : tb
